// *** hdl/ccpm_pkg.sv ***
// shared constants and types for the capture/compare/pwm mode control block
package ccpm_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_UNIT_ONE_CTRL  = 6'h17;
    localparam logic [5:0] IDX_UNIT_TWO_CTRL  = 6'h1d;
    localparam logic [5:0] IDX_STATUS         = 6'h20;
    localparam logic [5:0] IDX_MASK           = 6'h21;
    localparam logic [5:0] IDX_VALUE_ONE      = 6'h22;
    localparam logic [5:0] IDX_VALUE_TWO      = 6'h23;

    // ----------------------------------------------------------------
    // mode field encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_OFF           = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL      = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE      = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4     = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16    = 4'h7;
    localparam logic [3:0] MODE_CMP_SET       = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR       = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT      = 4'ha;
    localparam logic [3:0] MODE_CMP_SPEC      = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP       = 2'h3;

    // ----------------------------------------------------------------
    // edge prescaler terminal counts and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] PRESC_RESET        = 4'h0;
    localparam logic [3:0] PRESC_FOUR_LAST    = 4'h3;
    localparam logic [3:0] PRESC_SIXTEEN_LAST = 4'hf;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       duty_lsb_high;
        logic       duty_lsb_low;
        logic [3:0] unit_mode_field;
    } ccpm_ctrl_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } ccpm_avm_req_t;

    typedef enum logic [0:0] {
        CCPM_BUS_IDLE = 1'b0,
        CCPM_BUS_ACK  = 1'b1
    } ccpm_bus_phase_t;

    typedef struct packed {
        ccpm_bus_phase_t phase;
        logic [31:0]     readdata;
    } ccpm_avs_state_t;

    typedef struct packed {
        logic       pin_prev;
        logic       match_prev;
        logic [3:0] presc;
        logic       pin_level;
        logic       event_pulse;
        logic       special_pulse;
    } ccpm_unit_state_t;

    typedef struct packed {
        ccpm_ctrl_t [1:0]       ctrl;
        logic [1:0][15:0]       value;
        logic [1:0]             flag;
        logic [1:0]             mask;
        ccpm_unit_state_t [1:0] unit;
        logic                   adc_start;
    } ccpm_top_state_t;

    localparam ccpm_avs_state_t AVS_RESET = '0;
    localparam ccpm_top_state_t TOP_RESET = '0;

endpackage : ccpm_pkg

// *** hdl/ccpm_avs_slave.sv ***
// avalon-mm slave front end with one wait state per access
`timescale 1ns/1ps
module ccpm_avs_slave
    import ccpm_pkg::*;
(
    input  wire logic          mclk_in,
    input  wire logic          rstn_in,
    input  wire ccpm_avm_req_t avm_req_in,
    input  wire logic [31:0]   rdata_in,
    output logic [31:0]        avm_readdata_out,
    output logic               avm_waitrequest_out,
    output logic               wr_strobe_out,
    output logic [5:0]         reg_index_out
);

    ccpm_avs_state_t r;
    ccpm_avs_state_t next_r;
    logic            hit;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // unaligned addresses are unmapped: reads give zero, writes vanish
    assign hit           = (avm_req_in.address[1:0] == 2'b00);
    assign reg_index_out = avm_req_in.address[7:2];

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // first cycle of a request always waits, so read data is a flop
    always_comb begin
        next_r = r;
        if (r.phase == CCPM_BUS_IDLE) begin
            if (avm_req_in.read || avm_req_in.write) begin
                next_r.phase = CCPM_BUS_ACK;
            end
            if (avm_req_in.read) begin
                next_r.readdata = hit ? rdata_in : 32'h0000_0000;
            end
        end else begin
            next_r.phase = CCPM_BUS_IDLE;
        end
    end

    // state register
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= AVS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs: write lands at the edge that ends the ack cycle
    assign avm_waitrequest_out = (avm_req_in.read || avm_req_in.write) && (r.phase == CCPM_BUS_IDLE);
    assign wr_strobe_out       = avm_req_in.write && hit && (r.phase == CCPM_BUS_ACK);
    assign avm_readdata_out    = r.readdata;

endmodule : ccpm_avs_slave

// *** hdl/ccpm_mode_ctrl.sv ***
// mode control for two capture/compare/pwm units with register access
//
// What this block does
// - in pwm mode bits 5-4 of the control register are the two low bits of the 10-bit duty, above them the duty byte.
// - mode 0000 disables the unit and returns its capture, compare and pwm logic to reset.
// - mode 0100 captures the timer and sets the unit flag on every falling pin edge.
// - mode 0111 captures once per sixteen rising pin edges through an edge prescaler.
// - mode 1000 drives the pin high on a compare match and sets the unit flag.
// - mode 1001 drives the pin low on a compare match and sets the unit flag.
// - mode 1010 only sets the unit flag on a match and leaves the pin as it is.
// - mode 1011 sets the flag and issues a special event on a match, leaving the pin alone.
// - a special event resets the shared timer, and from unit two also starts a conversion if the converter is on.
`timescale 1ns/1ps
module ccpm_mode_ctrl
    import ccpm_pkg::*;
(
    input  wire logic          mclk_in,
    input  wire logic          rstn_in,
    input  wire ccpm_avm_req_t avm_req_in,
    output logic [31:0]        avm_readdata_out,
    output logic               avm_waitrequest_out,
    input  wire logic [15:0]   shared_sixteen_bit_timer_in,
    input  wire logic          adc_enabled_in,
    input  wire logic [1:0]    unit_io_pin_in,
    output logic [1:0]         unit_io_pin_out,
    output logic [1:0]         unit_io_pin_oe_out,
    output logic               timer_reset_out,
    output logic               adc_start_out,
    output logic               irq_out
);

    ccpm_top_state_t r;
    ccpm_top_state_t next_r;
    logic [31:0]     rdata;
    logic            wr_strobe;
    logic [5:0]      reg_index;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    ccpm_avs_slave u_avs (
        .mclk_in             (mclk_in),
        .rstn_in             (rstn_in),
        .avm_req_in          (avm_req_in),
        .rdata_in            (rdata),
        .avm_readdata_out    (avm_readdata_out),
        .avm_waitrequest_out (avm_waitrequest_out),
        .wr_strobe_out       (wr_strobe),
        .reg_index_out       (reg_index)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // unused upper bits pad with zero, so bits 7:6 of control read 0
    always_comb begin
        case (reg_index)
            IDX_UNIT_ONE_CTRL: rdata = {26'h0000000, r.ctrl[0]};
            IDX_UNIT_TWO_CTRL: rdata = {26'h0000000, r.ctrl[1]};
            IDX_STATUS:        rdata = {30'h00000000, r.flag};
            IDX_MASK:          rdata = {30'h00000000, r.mask};
            IDX_VALUE_ONE:     rdata = {16'h0000, r.value[0]};
            IDX_VALUE_TWO:     rdata = {16'h0000, r.value[1]};
            default:           rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // unit engines, register writes, flags
    // ----------------------------------------------------------------
    // engines run first, bus writes next, then captures and flag sets
    // so that hardware events win over a same-cycle software write
    always_comb begin
        logic [3:0] mode;
        logic       pin;
        logic       rise;
        logic       fall;
        logic       match;
        logic       hit;
        logic [1:0] cap;
        mode   = MODE_OFF;
        pin    = 1'b0;
        rise   = 1'b0;
        fall   = 1'b0;
        match  = 1'b0;
        hit    = 1'b0;
        cap    = 2'b00;
        next_r = r;
        for (int i = 0; i < 2; i++) begin
            mode  = r.ctrl[i].unit_mode_field;
            pin   = unit_io_pin_in[i];
            rise  = pin && !r.unit[i].pin_prev;
            fall  = !pin && r.unit[i].pin_prev;
            match = (shared_sixteen_bit_timer_in == r.value[i]);
            hit   = match && !r.unit[i].match_prev;   // one event per match
            next_r.unit[i].pin_prev      = pin;
            next_r.unit[i].match_prev    = match;
            next_r.unit[i].event_pulse   = 1'b0;
            next_r.unit[i].special_pulse = 1'b0;
            case (mode)
                MODE_OFF: begin
                    next_r.unit[i].presc     = PRESC_RESET;
                    next_r.unit[i].pin_level = 1'b0;
                end
                MODE_CAP_FALL: begin
                    cap[i] = fall;
                end
                MODE_CAP_RISE: begin
                    cap[i] = rise;
                end
                MODE_CAP_RISE4, MODE_CAP_RISE16: begin
                    if (rise) begin
                        if (r.unit[i].presc == ((mode == MODE_CAP_RISE4) ? PRESC_FOUR_LAST : PRESC_SIXTEEN_LAST)) begin
                            next_r.unit[i].presc = PRESC_RESET;
                            cap[i]               = 1'b1;
                        end else begin
                            next_r.unit[i].presc = r.unit[i].presc + 4'h1;
                        end
                    end
                end
                MODE_CMP_SET: begin
                    if (hit) begin
                        next_r.unit[i].pin_level   = 1'b1;
                        next_r.unit[i].event_pulse = 1'b1;
                    end
                end
                MODE_CMP_CLR: begin
                    if (hit) begin
                        next_r.unit[i].pin_level   = 1'b0;
                        next_r.unit[i].event_pulse = 1'b1;
                    end
                end
                MODE_CMP_SOFT: begin
                    next_r.unit[i].event_pulse = hit;
                end
                MODE_CMP_SPEC: begin
                    next_r.unit[i].event_pulse   = hit;
                    next_r.unit[i].special_pulse = hit;
                end
                default: begin
                    // pwm: high while the timer low bits sit below the duty
                    if (mode[3:2] == MODE_PWM_TOP) begin
                        next_r.unit[i].pin_level = shared_sixteen_bit_timer_in[9:0] <
                            {r.value[i][7:0], r.ctrl[i].duty_lsb_high, r.ctrl[i].duty_lsb_low};
                    end
                end
            endcase
            if (cap[i]) begin
                next_r.unit[i].event_pulse = 1'b1;
            end
        end
        // software writes; a control write restarts the edge prescaler
        if (wr_strobe) begin
            case (reg_index)
                IDX_UNIT_ONE_CTRL: begin
                    next_r.ctrl[0]       = ccpm_ctrl_t'(avm_req_in.writedata[5:0]);
                    next_r.unit[0].presc = PRESC_RESET;
                end
                IDX_UNIT_TWO_CTRL: begin
                    next_r.ctrl[1]       = ccpm_ctrl_t'(avm_req_in.writedata[5:0]);
                    next_r.unit[1].presc = PRESC_RESET;
                end
                IDX_STATUS:    next_r.flag     = r.flag & ~avm_req_in.writedata[1:0];
                IDX_MASK:      next_r.mask     = avm_req_in.writedata[1:0];
                IDX_VALUE_ONE: next_r.value[0] = avm_req_in.writedata[15:0];
                IDX_VALUE_TWO: next_r.value[1] = avm_req_in.writedata[15:0];
                default: ;
            endcase
        end
        // capture beats a same-cycle value write, flag set beats clear
        for (int i = 0; i < 2; i++) begin
            if (cap[i]) begin
                next_r.value[i] = shared_sixteen_bit_timer_in;
            end
            next_r.flag[i] = next_r.flag[i] | next_r.unit[i].event_pulse;
        end
        next_r.adc_start = next_r.unit[1].special_pulse && adc_enabled_in;
    end

    // state register; everything clears at reset
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= TOP_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // the pin is driven in compare and pwm modes only
    for (genvar g = 0; g < 2; g++) begin : g_pin
        assign unit_io_pin_out[g]    = r.unit[g].pin_level;
        assign unit_io_pin_oe_out[g] = r.ctrl[g].unit_mode_field[3];
    end

    // either unit's special event clears the shared timer
    assign timer_reset_out = r.unit[0].special_pulse | r.unit[1].special_pulse;
    assign adc_start_out   = r.adc_start;
    assign irq_out         = |(r.flag & r.mask);

    // ----------------------------------------------------------------
    // assertion helpers
    // ----------------------------------------------------------------
    logic [3:0] mode0;
    logic [3:0] mode1;
    logic       rise0;
    logic       fall0;
    logic       edge_m0;
    logic       edge_m1;
    logic       pwm_mode0;
    logic       pwm_high0;
    logic       ctrl_wr0;
    logic [3:0] rise_cnt_h;

    assign mode0     = r.ctrl[0].unit_mode_field;
    assign mode1     = r.ctrl[1].unit_mode_field;
    assign rise0     = unit_io_pin_in[0] && !r.unit[0].pin_prev;
    assign fall0     = !unit_io_pin_in[0] && r.unit[0].pin_prev;
    assign edge_m0   = (shared_sixteen_bit_timer_in == r.value[0]) && !r.unit[0].match_prev;
    assign edge_m1   = (shared_sixteen_bit_timer_in == r.value[1]) && !r.unit[1].match_prev;
    assign pwm_mode0 = (mode0[3:2] == MODE_PWM_TOP);
    assign pwm_high0 = shared_sixteen_bit_timer_in[9:0] <
                       {r.value[0][7:0], r.ctrl[0].duty_lsb_high, r.ctrl[0].duty_lsb_low};
    assign ctrl_wr0  = wr_strobe && (reg_index == IDX_UNIT_ONE_CTRL);

    // independent count of rising edges seen in sixteen-edge mode
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rise_cnt_h <= 4'h0;
        end else if (mode0 != MODE_CAP_RISE16 || ctrl_wr0) begin
            rise_cnt_h <= 4'h0;
        end else if (rise0) begin
            rise_cnt_h <= rise_cnt_h + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    property p_pwm_duty;
        pwm_mode0 && !ctrl_wr0 |=> unit_io_pin_out[0] == $past(pwm_high0) && unit_io_pin_oe_out[0];
    endproperty
    a_pwm_duty: assert property (p_pwm_duty) else $error("pwm level does not follow duty");

    property p_off;
        (mode0 == MODE_OFF) && !ctrl_wr0 |=> !unit_io_pin_out[0] && !unit_io_pin_oe_out[0] && (r.unit[0].presc == 4'h0);
    endproperty
    a_off: assert property (p_off) else $error("disabled unit not held in reset");

    property p_cap_fall;
        (mode0 == MODE_CAP_FALL) && fall0 |=> r.flag[0] && (r.value[0] == $past(shared_sixteen_bit_timer_in));
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("falling edge capture missed");

    property p_cap16;
        (mode0 == MODE_CAP_RISE16) && rise0 && !ctrl_wr0 |=>
            r.unit[0].event_pulse == ($past(rise_cnt_h) == 4'hf);
    endproperty
    a_cap16: assert property (p_cap16) else $error("sixteenth edge capture wrong");

    property p_cmp_set;
        (mode0 == MODE_CMP_SET) && edge_m0 && !ctrl_wr0 |=> unit_io_pin_out[0] && r.flag[0];
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("match did not set the pin");

    property p_cmp_clr;
        (mode0 == MODE_CMP_CLR) && edge_m0 && !ctrl_wr0 |=> !unit_io_pin_out[0] && r.flag[0];
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("match did not clear the pin");

    property p_cmp_soft;
        (mode0 == MODE_CMP_SOFT) && edge_m0 |=> r.flag[0] && $stable(unit_io_pin_out[0]) && !r.unit[0].special_pulse;
    endproperty
    a_cmp_soft: assert property (p_cmp_soft) else $error("software compare touched the pin");

    property p_cmp_spec;
        (mode0 == MODE_CMP_SPEC) && edge_m0 |=> r.flag[0] && timer_reset_out && $stable(unit_io_pin_out[0]);
    endproperty
    a_cmp_spec: assert property (p_cmp_spec) else $error("special event missing");

    property p_adc;
        (mode1 == MODE_CMP_SPEC) && edge_m1 |=> timer_reset_out && (adc_start_out == $past(adc_enabled_in));
    endproperty
    a_adc: assert property (p_adc) else $error("conversion start wrong on special event");

    property p_cap_rise;
        (mode0 == MODE_CAP_RISE) && rise0 |=> r.flag[0] && (r.value[0] == $past(shared_sixteen_bit_timer_in));
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("rising edge capture missed");

    property p_ctrl_read;
        avm_req_in.read && !avm_waitrequest_out && (reg_index == IDX_UNIT_ONE_CTRL)
            |-> avm_readdata_out[31:6] == 26'h0000000;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("unused control bits read nonzero");

endmodule : ccpm_mode_ctrl

// *** sim/ccpm_far_side.sv ***
// behavioural model of the shared timer and the unit pins outside the block
`timescale 1ns/1ps
module ccpm_far_side
    import ccpm_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic        run_in,
    input  wire logic        load_in,
    input  wire logic [15:0] load_val_in,
    input  wire logic        timer_reset_in,
    input  wire logic [1:0]  ext_level_in,
    input  wire logic [1:0]  pin_drive_in,
    input  wire logic [1:0]  pin_oe_in,
    output logic [15:0]      timer_out,
    output logic [1:0]       pin_level_out
);
    // timer: load wins so the bench can park it on a known value
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            timer_out <= 16'h0000;
        else if (load_in)
            timer_out <= load_val_in;
        else if (timer_reset_in)
            timer_out <= 16'h0000;
        else if (run_in)
            timer_out <= timer_out + 16'h0001;
    end

    // pin wire: the unit wins while it drives, else the outside level
    assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & ext_level_in);
endmodule : ccpm_far_side

// *** sim/ccpm_mode_ctrl_bench.sv ***
// self-checking bench for the capture/compare/pwm mode control block
`timescale 1ns/1ps
module ccpm_mode_ctrl_bench
    import ccpm_pkg::*;
;
    logic mclk_in = 1'b0, rstn_in = 1'b0, adc_en = 1'b0, run = 1'b0, load = 1'b0;
    logic [15:0] load_val = 16'h0000, timer;
    logic [1:0] ext = 2'h0, pin_lvl, pin_out, pin_oe;
    ccpm_avm_req_t req = '0;
    logic [31:0] rdata, d;
    logic waitreq, tmr_rst, adc_start, irq;
    int bad_count = 0, num_checks = 0, n_rst = 0, n_adc = 0;
    localparam logic [3:0] RMODE [3] = '{MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
    localparam int RCNT [3] = '{1, 4, 16};
    localparam logic [3:0] CMODE [3] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR};
    localparam logic CPIN [3] = '{1'b1, 1'b1, 1'b0};
    localparam logic [31:0] PCTL [4] = '{32'h3c, 32'h3c, 32'h0c, 32'h0c};
    localparam logic [15:0] PTM [4] = '{16'h6, 16'h7, 16'h6, 16'h3};
    localparam logic PPIN [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    always #20 mclk_in = ~mclk_in;

    ccpm_mode_ctrl DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .avm_req_in(req), .avm_readdata_out(rdata),
        .avm_waitrequest_out(waitreq), .shared_sixteen_bit_timer_in(timer), .adc_enabled_in(adc_en),
        .unit_io_pin_in(pin_lvl), .unit_io_pin_out(pin_out), .unit_io_pin_oe_out(pin_oe),
        .timer_reset_out(tmr_rst), .adc_start_out(adc_start), .irq_out(irq));
    ccpm_far_side FAR (.mclk_in(mclk_in), .rstn_in(rstn_in), .run_in(run), .load_in(load),
        .load_val_in(load_val), .timer_reset_in(tmr_rst), .ext_level_in(ext), .pin_drive_in(pin_out),
        .pin_oe_in(pin_oe), .timer_out(timer), .pin_level_out(pin_lvl));

    // pulse counters: flops update late in the step, so old values are read here
    always @(posedge mclk_in) begin
        if (tmr_rst === 1'b1) n_rst <= n_rst + 1;
        if (adc_start === 1'b1) n_adc <= n_adc + 1;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request held until waitrequest is seen low, then released at that edge
    task automatic acc(input logic w, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk_in);
        req <= '{read: !w, write: w, address: adr, writedata: wd};
        // values read right after the edge are the ones the slave sampled there
        do begin
            @(posedge mclk_in);
        end while (waitreq !== 1'b0);
        rd = rdata;
        req <= '0;
    endtask : acc

    task automatic wreg(input logic [5:0] i, input logic [31:0] v);
        logic [31:0] x;
        acc(1'b1, {i, 2'b00}, v, x);
    endtask : wreg

    task automatic rreg(input logic [5:0] i, input logic [31:0] e, input string nm);
        logic [31:0] x;
        acc(1'b0, {i, 2'b00}, 32'h0, x);
        chk(nm, e, x);
    endtask : rreg

    task automatic settm(input logic [15:0] v, input logic r);
        @(posedge mclk_in);
        load <= 1'b1;
        load_val <= v;
        run <= r;
        @(posedge mclk_in);
        load <= 1'b0;
    endtask : settm

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            ext[0] <= 1'b1;
            repeat (2) @(posedge mclk_in);
            ext[0] <= 1'b0;
            @(posedge mclk_in);
        end
    endtask : pulse

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        rreg(IDX_UNIT_ONE_CTRL, 32'h0, "ctrl one reset");
        wreg(IDX_UNIT_TWO_CTRL, 32'hff);
        rreg(IDX_UNIT_TWO_CTRL, 32'h3f, "ctrl two top bits");
        acc(1'b0, {IDX_UNIT_TWO_CTRL, 2'b01}, 32'h0, d);
        chk("unaligned read", 32'h0, d);
        rreg(6'h30, 32'h0, "unmapped read");
        wreg(IDX_UNIT_TWO_CTRL, 32'h0);
        $display("test registers done");
        // falling edge capture, interrupt mask, no capture on rise
        ext[0] <= 1'b1;
        settm(16'h1234, 1'b0);
        wreg(IDX_UNIT_ONE_CTRL, {28'h0, MODE_CAP_FALL});
        wreg(IDX_MASK, 32'h1);
        ext[0] <= 1'b0;
        repeat (4) @(negedge mclk_in);
        chk("irq", 32'h1, {31'h0, irq});
        rreg(IDX_VALUE_ONE, 32'h1234, "capture value");
        rreg(IDX_STATUS, 32'h1, "capture flag");
        wreg(IDX_MASK, 32'h0);
        @(negedge mclk_in);
        chk("irq masked", 32'h0, {31'h0, irq});
        wreg(IDX_STATUS, 32'h1);
        settm(16'h5555, 1'b0);
        // rise only: the fall that follows is a capture of its own
        ext[0] <= 1'b1;
        rreg(IDX_VALUE_ONE, 32'h1234, "value after rise");
        rreg(IDX_STATUS, 32'h0, "flag after rise");
        ext[0] <= 1'b0;
        rreg(IDX_VALUE_ONE, 32'h5555, "value after fall");
        $display("test falling capture done");
        // rising edge prescalers, each restarted by the control write
        for (int k = 0; k < 3; k++) begin
            wreg(IDX_UNIT_ONE_CTRL, {28'h0, RMODE[k]});
            wreg(IDX_STATUS, 32'h3);
            pulse(RCNT[k] - 1);
            rreg(IDX_STATUS, 32'h0, "flag before last edge");
            pulse(1);
            rreg(IDX_STATUS, 32'h1, "flag on last edge");
        end
        $display("test rising capture done");
        // compare actions on unit one: set, keep, clear
        wreg(IDX_VALUE_ONE, 32'h40);
        for (int k = 0; k < 3; k++) begin
            wreg(IDX_UNIT_ONE_CTRL, {28'h0, CMODE[k]});
            wreg(IDX_STATUS, 32'h1);
            settm(16'h3e, 1'b1);
            repeat (6) @(posedge mclk_in);
            run <= 1'b0;
            chk("compare pin", {31'h0, CPIN[k]}, {31'h0, pin_out[0]});
            chk("compare oe", 32'h1, {31'h0, pin_oe[0]});
            rreg(IDX_STATUS, 32'h1, "compare flag");
        end
        // special event on both units, converter on then off
        wreg(IDX_UNIT_ONE_CTRL, {28'h0, MODE_CMP_SPEC});
        wreg(IDX_VALUE_TWO, 32'h40);
        wreg(IDX_UNIT_TWO_CTRL, {28'h0, MODE_CMP_SPEC});
        wreg(IDX_STATUS, 32'h3);
        for (int k = 0; k < 2; k++) begin
            adc_en <= (k == 0);
            settm(16'h3e, 1'b1);
            repeat (8) @(posedge mclk_in);
            run <= 1'b0;
            chk("timer resets", k + 1, n_rst);
            chk("conversions", 32'h1, n_adc);
        end
        rreg(IDX_STATUS, 32'h3, "special flag");
        chk("special pin", 32'h0, {31'h0, pin_out[1]});
        $display("test compare done");
        // pwm duty with the two low bits from the control register
        wreg(IDX_VALUE_ONE, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wreg(IDX_UNIT_ONE_CTRL, PCTL[k]);
            settm(PTM[k], 1'b0);
            repeat (3) @(posedge mclk_in);
            chk("pwm pin", {31'h0, PPIN[k]}, {31'h0, pin_out[0]});
        end
        wreg(IDX_UNIT_ONE_CTRL, 32'h0);
        repeat (2) @(negedge mclk_in);
        chk("disabled pin", 32'h0, {31'h0, pin_out[0]});
        chk("disabled oe", 32'h0, {31'h0, pin_oe[0]});
        // an unlisted mode must ignore pin edges
        wreg(IDX_UNIT_ONE_CTRL, 32'h1);
        wreg(IDX_STATUS, 32'h3);
        pulse(1);
        rreg(IDX_STATUS, 32'h0, "unlisted mode flag");
        $display("test pwm and disable done");
        end_sim();
    end
endmodule : ccpm_mode_ctrl_bench
